// ---- hdl/pin_change_pkg.sv ----
// Shared constants and types for the pin change interrupt block
package pin_change_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_RISE_EN = 8'h04;
   localparam logic [7:0] ADDR_FALL_EN = 8'h08;
   localparam logic [7:0] ADDR_FLAGS = 8'h0C;
   localparam logic [7:0] ADDR_LEVEL = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
   // Field positions in the interrupt control register
   localparam int CTL_SUMMARY_BIT = 0;
   localparam int CTL_MASTER_BIT = 3;
   // Event bits in the interrupt status and mask registers
   localparam int EVT_COUNT = 2;
   localparam int EVT_CHANGE_BIT = 0;
   localparam int EVT_WAKE_BIT = 1;
   // Reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] EDGE_EN_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Register decode result
   typedef enum logic [2:0] {
      SEL_CONTROL,
      SEL_RISE_EN,
      SEL_FALL_EN,
      SEL_FLAGS,
      SEL_LEVEL,
      SEL_IRQ_STATUS,
      SEL_IRQ_MASK,
      SEL_NONE
   } reg_sel_t;
endpackage

// ---- hdl/pin_edge_detect.sv ----
// Pin synchroniser and per-pin edge detector
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect #(
   parameter int WIDTH = 6
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Asynchronous pins
   input wire logic [WIDTH-1:0] pin_in,
   // Filtered level and one-cycle edge pulses
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] sync1_reg;
   logic [WIDTH-1:0] sync2_reg;
   logic [WIDTH-1:0] sync3_reg;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_pin
         // Level changes once the second and third stages agree
         always_ff @(posedge mclk) begin
            if (!reset_n) begin
               level[i] <= 1'b0;
               rise[i] <= 1'b0;
               fall[i] <= 1'b0;
            end else begin
               rise[i] <= (sync2_reg[i] == sync3_reg[i]) && sync3_reg[i] && !level[i];
               fall[i] <= (sync2_reg[i] == sync3_reg[i]) && !sync3_reg[i] && level[i];
               if (sync2_reg[i] == sync3_reg[i]) begin
                  level[i] <= sync3_reg[i];
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ---- hdl/sticky_flag_bank.sv ----
// Bank of hardware-set flags with software write, set wins over write
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_bank #(
   parameter int WIDTH = 6,
   parameter bit WRITE_ONE_CLEARS = 1'b0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Hardware set
   input wire logic [WIDTH-1:0] set,
   // Software write
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   // Flags
   output logic [WIDTH-1:0] flags
);
   logic [WIDTH-1:0] written;

   always_comb begin
      if (!wr_en) begin
         written = flags;
      end else if (WRITE_ONE_CLEARS) begin
         written = flags & ~wr_data;
      end else begin
         written = wr_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         flags <= '0;
      end else begin
         flags <= written | set;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/pin_change_interrupt.sv ----
// Pin change interrupt block with AXI4-Lite register access
//
// Notes on behaviour
// - The change interrupt request is raised only while the master enable is set.
// - Edges keep setting pin flags with the master enable cleared; only the request stops.
// - Each pin has a rising-edge detector gated by its rising enable bit.
// - Each pin has a falling-edge detector gated by its falling enable bit.
// - With both enable bits set a pin responds to either edge.
// - An enabled edge sets the pin flag and requests an interrupt when enabled.
// - The summary flag is the OR of all pin flags.
// - Writing zero to a pin flag clears it.
// - An edge during a flag write leaves that pin flag set, whatever was written.
// - A pin change wakes the device from sleep when the master enable is set.
// - Edges during sleep update the pin flags before execution resumes.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pin_change_interrupt #(
   parameter int PIN_COUNT = 6,
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Port pins
   input wire logic [PIN_COUNT-1:0] port_pins,
   // Power control
   input wire logic sleep_active,
   output logic wake_request,
   // Interrupt
   output logic irq,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Address decode, shared by reads and writes
   function automatic pin_change_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [7:0] a;
      a = 8'(addr);
      if (addr[1:0] != 2'h0) begin
         decode = pin_change_pkg::SEL_NONE;
      end else if (a == pin_change_pkg::ADDR_CONTROL) begin
         decode = pin_change_pkg::SEL_CONTROL;
      end else if (a == pin_change_pkg::ADDR_RISE_EN) begin
         decode = pin_change_pkg::SEL_RISE_EN;
      end else if (a == pin_change_pkg::ADDR_FALL_EN) begin
         decode = pin_change_pkg::SEL_FALL_EN;
      end else if (a == pin_change_pkg::ADDR_FLAGS) begin
         decode = pin_change_pkg::SEL_FLAGS;
      end else if (a == pin_change_pkg::ADDR_LEVEL) begin
         decode = pin_change_pkg::SEL_LEVEL;
      end else if (a == pin_change_pkg::ADDR_IRQ_STATUS) begin
         decode = pin_change_pkg::SEL_IRQ_STATUS;
      end else if (a == pin_change_pkg::ADDR_IRQ_MASK) begin
         decode = pin_change_pkg::SEL_IRQ_MASK;
      end else begin
         decode = pin_change_pkg::SEL_NONE;
      end
   endfunction

   // Widen per-pin values to a register byte
   function automatic logic [7:0] pad_pins(input logic [PIN_COUNT-1:0] v);
      logic [7:0] r;
      r = 8'h00;
      r[PIN_COUNT-1:0] = v;
      pad_pins = r;
   endfunction

   // Registers
   logic master_enable_reg;
   logic [PIN_COUNT-1:0] rise_en_reg;
   logic [PIN_COUNT-1:0] fall_en_reg;
   logic [pin_change_pkg::EVT_COUNT-1:0] irq_mask_reg;
   logic [PIN_COUNT-1:0] pin_flags;
   logic [pin_change_pkg::EVT_COUNT-1:0] irq_status;

   // Edge detection
   logic [PIN_COUNT-1:0] pin_level;
   logic [PIN_COUNT-1:0] pin_rise;
   logic [PIN_COUNT-1:0] pin_fall;
   logic [PIN_COUNT-1:0] pin_edge;
   logic any_edge;
   logic summary_flag;
   logic [pin_change_pkg::EVT_COUNT-1:0] event_set;

   // Bus state
   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_W-1:0] wr_addr_reg;
   logic [31:0] wr_data_reg;
   logic [3:0] wr_strb_reg;
   logic do_write;
   logic wr_byte0;
   pin_change_pkg::reg_sel_t wr_sel;
   pin_change_pkg::reg_sel_t rd_sel;
   logic [7:0] rd_byte;

   pin_edge_detect #(
      .WIDTH(PIN_COUNT)
   ) u_edge (
      .mclk(mclk),
      .reset_n(reset_n),
      .pin_in(port_pins),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Enabled edges; detection runs regardless of master enable and of sleep
   assign pin_edge = (pin_rise & rise_en_reg) | (pin_fall & fall_en_reg);
   assign any_edge = |pin_edge;
   assign summary_flag = |pin_flags;

   // Write path decode
   assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_sel = decode(wr_addr_reg);
   assign wr_byte0 = do_write && wr_strb_reg[0];

   sticky_flag_bank #(
      .WIDTH(PIN_COUNT),
      .WRITE_ONE_CLEARS(1'b0)
   ) u_pin_flags (
      .mclk(mclk),
      .reset_n(reset_n),
      .set(pin_edge),
      .wr_en(wr_byte0 && (wr_sel == pin_change_pkg::SEL_FLAGS)),
      .wr_data(wr_data_reg[PIN_COUNT-1:0]),
      .flags(pin_flags)
   );

   always_comb begin
      event_set = '0;
      event_set[pin_change_pkg::EVT_CHANGE_BIT] = any_edge;
      event_set[pin_change_pkg::EVT_WAKE_BIT] = any_edge && sleep_active && master_enable_reg;
   end

   sticky_flag_bank #(
      .WIDTH(pin_change_pkg::EVT_COUNT),
      .WRITE_ONE_CLEARS(1'b1)
   ) u_irq_status (
      .mclk(mclk),
      .reset_n(reset_n),
      .set(event_set),
      .wr_en(wr_byte0 && (wr_sel == pin_change_pkg::SEL_IRQ_STATUS)),
      .wr_data(wr_data_reg[pin_change_pkg::EVT_COUNT-1:0]),
      .flags(irq_status)
   );

   // Control registers
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         master_enable_reg <= pin_change_pkg::CONTROL_RESET[pin_change_pkg::CTL_MASTER_BIT];
         rise_en_reg <= pin_change_pkg::EDGE_EN_RESET[PIN_COUNT-1:0];
         fall_en_reg <= pin_change_pkg::EDGE_EN_RESET[PIN_COUNT-1:0];
         irq_mask_reg <= pin_change_pkg::IRQ_MASK_RESET;
      end else if (wr_byte0) begin
         if (wr_sel == pin_change_pkg::SEL_CONTROL) begin
            master_enable_reg <= wr_data_reg[pin_change_pkg::CTL_MASTER_BIT];
         end else if (wr_sel == pin_change_pkg::SEL_RISE_EN) begin
            rise_en_reg <= wr_data_reg[PIN_COUNT-1:0];
         end else if (wr_sel == pin_change_pkg::SEL_FALL_EN) begin
            fall_en_reg <= wr_data_reg[PIN_COUNT-1:0];
         end else if (wr_sel == pin_change_pkg::SEL_IRQ_MASK) begin
            irq_mask_reg <= wr_data_reg[pin_change_pkg::EVT_COUNT-1:0];
         end
      end
   end

   // Interrupt request, gated by the master enable
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= master_enable_reg && |(irq_status & irq_mask_reg);
      end
   end

   // Wake request, held until the device leaves sleep
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wake_request <= 1'b0;
      end else if (!sleep_active) begin
         wake_request <= 1'b0;
      end else if (any_edge && master_enable_reg) begin
         wake_request <= 1'b1;
      end
   end

   // Write address channel
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         aw_held_reg <= 1'b0;
         wr_addr_reg <= '0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         wr_addr_reg <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end else if (!aw_held_reg && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   // Write data channel
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         w_held_reg <= 1'b0;
         wr_data_reg <= 32'h00000000;
         wr_strb_reg <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         wr_data_reg <= s_axi_wdata;
         wr_strb_reg <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end else if (!w_held_reg && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Write response channel
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pin_change_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         if (wr_sel == pin_change_pkg::SEL_NONE) begin
            s_axi_bresp <= pin_change_pkg::RESP_SLVERR;
         end else begin
            s_axi_bresp <= pin_change_pkg::RESP_OKAY;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read data selection
   assign rd_sel = decode(s_axi_araddr);

   always_comb begin
      rd_byte = 8'h00;
      case (rd_sel)
         pin_change_pkg::SEL_CONTROL: begin
            rd_byte[pin_change_pkg::CTL_MASTER_BIT] = master_enable_reg;
            rd_byte[pin_change_pkg::CTL_SUMMARY_BIT] = summary_flag;
         end
         pin_change_pkg::SEL_RISE_EN: begin
            rd_byte = pad_pins(rise_en_reg);
         end
         pin_change_pkg::SEL_FALL_EN: begin
            rd_byte = pad_pins(fall_en_reg);
         end
         pin_change_pkg::SEL_FLAGS: begin
            rd_byte = pad_pins(pin_flags);
         end
         pin_change_pkg::SEL_LEVEL: begin
            rd_byte = pad_pins(pin_level);
         end
         pin_change_pkg::SEL_IRQ_STATUS: begin
            rd_byte[pin_change_pkg::EVT_COUNT-1:0] = irq_status;
         end
         pin_change_pkg::SEL_IRQ_MASK: begin
            rd_byte[pin_change_pkg::EVT_COUNT-1:0] = irq_mask_reg;
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   // Read address and data channels
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= pin_change_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_byte};
         if (rd_sel == pin_change_pkg::SEL_NONE) begin
            s_axi_rresp <= pin_change_pkg::RESP_SLVERR;
         end else begin
            s_axi_rresp <= pin_change_pkg::RESP_OKAY;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- sim/pin_source.sv ----
// Model of the external logic that drives the port pins
`timescale 1ns/1ps
`default_nettype none
module pin_source #(
   parameter int WIDTH = 6
) (
   // Commanded levels
   input wire logic [WIDTH-1:0] target,
   // Pin levels
   output logic [WIDTH-1:0] pins
);
   // Pins move off the clock grid, like an unsynchronised source
   // Copies the level at time zero too, so the pins are known from 7 ns on
   always begin
      pins <= #7 target;
      @(target);
   end
endmodule
`default_nettype wire

// ---- sim/pin_change_interrupt_assertions.sv ----
// Port checks for the pin change interrupt block
`timescale 1ns/1ps
`default_nettype none
module pin_change_interrupt_assertions #(
   parameter int PIN_COUNT = 6,
   parameter int ADDR_W = 8
) (
   // Clock, reset, pins
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [PIN_COUNT-1:0] port_pins,
   input wire logic sleep_active,
   input wire logic wake_request,
   input wire logic irq,
   // Write channels
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [PIN_COUNT-1:0] pins_q;
   logic [3:0] pin_age;
   logic [3:0] wr_age;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Cycles since the last pin change and the last register write
   always_ff @(posedge mclk) begin
      pins_q <= port_pins;
      if (!reset_n)
         pin_age <= 4'hF;
      else if (port_pins != pins_q)
         pin_age <= 4'h0;
      else if (pin_age != 4'hF)
         pin_age <= pin_age + 4'h1;
   end
   always_ff @(posedge mclk) begin
      if (!reset_n)
         wr_age <= 4'hF;
      else if (s_axi_wvalid && s_axi_wready)
         wr_age <= 4'h0;
      else if (wr_age != 4'hF)
         wr_age <= wr_age + 4'h1;
   end
   irq_cause_a: assert property ($rose(irq) |-> pin_age < 4'hA || wr_age < 4'h8)
      else $error("irq rose without a pin change or write");
   irq_clear_a: assert property ($fell(irq) |-> wr_age < 4'h8)
      else $error("irq fell without a register write");
   wake_cause_a: assert property ($rose(wake_request) |-> $past(sleep_active) && pin_age < 4'hA)
      else $error("wake request without a pin change in sleep");
   wake_drop_a: assert property (wake_request && !sleep_active |=> !wake_request)
      else $error("wake request held after sleep ended");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered next cycle");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   reset_quiet_a: assert property ($rose(reset_n) |-> !irq && !s_axi_bvalid && !s_axi_rvalid && !wake_request)
      else $error("outputs active after reset");
   cover property ($rose(irq));
   cover property ($rose(wake_request));
   cover property (s_axi_bvalid && s_axi_bresp == pin_change_pkg::RESP_SLVERR);
endmodule
bind pin_change_interrupt pin_change_interrupt_assertions #(.PIN_COUNT(PIN_COUNT), .ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// ---- sim/pin_change_interrupt_tb.sv ----
// Self-checking bench for the pin change interrupt block
`timescale 1ns/1ps
`default_nettype none
module pin_change_interrupt_tb;
   logic mclk;
   logic reset_n;
   logic [5:0] target;
   logic [5:0] pins;
   logic sleep_active;
   logic wake_request;
   logic irq;
   logic [7:0] awaddr;
   logic [7:0] araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, got;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int miscompares;
   int num_checks;
   int i;
   pin_source #(.WIDTH(6)) u_pin_source (.target(target), .pins(pins));
   pin_change_interrupt #(.PIN_COUNT(6), .ADDR_W(8)) u_pin_change_interrupt (
      .mclk(mclk), .reset_n(reset_n), .port_pins(pins), .sleep_active(sleep_active),
      .wake_request(wake_request), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
      int n;
      logic ah, wh, bh;
      logic [1:0] r;
      @(posedge mclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bh = 1'b0;
      for (n = 0; n < 64 && !bh; n++) begin
         @(negedge mclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         r = bresp;
         @(posedge mclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!bh) begin
         miscompares++;
         stop_test();
      end
      chk(32'(r), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = 2'h0);
      int n;
      logic ah, rh;
      logic [1:0] r;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rh = 1'b0;
      for (n = 0; n < 64 && !rh; n++) begin
         @(negedge mclk);
         ah = arvalid && arready;
         rh = rvalid;
         v = rdata;
         r = rresp;
         @(posedge mclk);
         if (ah) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!rh) begin
         miscompares++;
         stop_test();
      end
      chk(32'(r), 32'(er));
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      rd(a, got);
      chk(got, {24'h000000, e});
   endtask
   task automatic clr(input logic [7:0] known);
      rd(pin_change_pkg::ADDR_FLAGS, got);
      wr(pin_change_pkg::ADDR_FLAGS, got[7:0] & ~known);
   endtask
   task automatic pin(input logic [5:0] v);
      target <= v;
      repeat (8) @(posedge mclk);
   endtask
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      reset_n = 1'b0;
      target = 6'h00;
      sleep_active = 1'b0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      miscompares = 0;
      num_checks = 0;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (2) @(posedge mclk);
      // Reset values and unmapped access
      rc(pin_change_pkg::ADDR_CONTROL, pin_change_pkg::CONTROL_RESET);
      rc(pin_change_pkg::ADDR_RISE_EN, pin_change_pkg::EDGE_EN_RESET);
      rc(pin_change_pkg::ADDR_FALL_EN, pin_change_pkg::EDGE_EN_RESET);
      rc(pin_change_pkg::ADDR_FLAGS, pin_change_pkg::FLAGS_RESET);
      rd(8'h1C, got, pin_change_pkg::RESP_SLVERR);
      chk(got, 32'h00000000);
      wr(8'h1C, 8'hFF, pin_change_pkg::RESP_SLVERR);
      // Per-pin edge selection with the master enable off
      wr(pin_change_pkg::ADDR_RISE_EN, 8'h05);
      wr(pin_change_pkg::ADDR_FALL_EN, 8'h06);
      // A write without the low byte lane changes nothing
      wstrb <= 4'hE;
      wr(pin_change_pkg::ADDR_RISE_EN, 8'h00);
      wstrb <= 4'hF;
      rc(pin_change_pkg::ADDR_RISE_EN, 8'h05);
      pin(6'h07);
      rc(pin_change_pkg::ADDR_FLAGS, 8'h05);
      rc(pin_change_pkg::ADDR_CONTROL, 8'h01);
      rc(pin_change_pkg::ADDR_LEVEL, 8'h07);
      chk(32'(irq), 32'h0);
      clr(8'h01);
      rc(pin_change_pkg::ADDR_FLAGS, 8'h04);
      clr(8'h04);
      rc(pin_change_pkg::ADDR_CONTROL, 8'h00);
      pin(6'h00);
      rc(pin_change_pkg::ADDR_FLAGS, 8'h06);
      clr(8'h06);
      // Master enable gates the request
      wr(pin_change_pkg::ADDR_IRQ_STATUS, 8'h03);
      wr(pin_change_pkg::ADDR_IRQ_MASK, 8'h03);
      wr(pin_change_pkg::ADDR_CONTROL, 8'h08);
      rc(pin_change_pkg::ADDR_CONTROL, 8'h08);
      chk(32'(irq), 32'h0);
      pin(6'h01);
      chk(32'(irq), 32'h1);
      wr(pin_change_pkg::ADDR_CONTROL, 8'h00);
      repeat (3) @(posedge mclk);
      chk(32'(irq), 32'h0);
      rc(pin_change_pkg::ADDR_FLAGS, 8'h01);
      wr(pin_change_pkg::ADDR_CONTROL, 8'h08);
      repeat (3) @(posedge mclk);
      chk(32'(irq), 32'h1);
      wr(pin_change_pkg::ADDR_IRQ_STATUS, 8'h03);
      clr(8'h01);
      // Edge arriving around a clearing write
      // The last pass lands the clearing write on the edge pulse itself
      for (i = 0; i < 3; i++) begin
         target <= target ^ 6'h04;
         repeat (i) @(posedge mclk);
         wr(pin_change_pkg::ADDR_FLAGS, 8'h00);
         repeat (8) @(posedge mclk);
         rc(pin_change_pkg::ADDR_FLAGS, 8'h04);
         clr(8'h04);
      end
      // Wake from sleep
      wr(pin_change_pkg::ADDR_IRQ_STATUS, 8'h03);
      sleep_active <= 1'b1;
      target <= target ^ 6'h04;
      for (i = 0; i < 20 && wake_request !== 1'b1; i++) @(posedge mclk);
      chk(32'(wake_request), 32'h1);
      rc(pin_change_pkg::ADDR_FLAGS, 8'h04);
      rc(pin_change_pkg::ADDR_IRQ_STATUS, 8'h03);
      rc(pin_change_pkg::ADDR_IRQ_MASK, 8'h03);
      chk(32'(irq), 32'h1);
      sleep_active <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(32'(wake_request), 32'h0);
      stop_test();
   end
endmodule
`default_nettype wire
